//--- common/flc_params.svh
// Purpose: constants of the lock-bit flash host controller
// Assumes: mclk at 40 MHz
// Notes:   times in ns, counts derived from them
// How it works
// - Clear all lock-bits: write 60H then D0H, then poll status.
// - Ready bit 7 is polled until one before errors are read.
// - Write FFH after the last lock-bit operation.
// - Read-array command follows any lock-bit operation.
// - Host waits the wake-up times after raising reset.
// - Set one lock-bit: write 60H then 01H inside the block.
`ifndef FLC_PARAMS_SVH
`define FLC_PARAMS_SVH
`define FLC_CLK_PERIOD_NS 25
`define FLC_WE_LOW_NS     50
`define FLC_WE_CYC  ((`FLC_WE_LOW_NS+`FLC_CLK_PERIOD_NS-1)/`FLC_CLK_PERIOD_NS)
`define FLC_RD_ACC_NS     120
`define FLC_RD_CYC  ((`FLC_RD_ACC_NS+`FLC_CLK_PERIOD_NS-1)/`FLC_CLK_PERIOD_NS)
`define FLC_CMD_LOCK_SETUP 8'h60
`define FLC_CMD_CLR_CONF   8'hD0
`define FLC_CMD_SET_CONF   8'h01
`define FLC_CMD_READ_ARRAY 8'hFF
`define FLC_CMD_READ_STAT  8'h70
`define FLC_CMD_CLR_STAT   8'h50
`define FLC_ST_READY_BIT   7
`define FLC_REG_CTRL       12'h000
`define FLC_REG_ADDR       12'h004
`define FLC_REG_STATUS     12'h008
`define FLC_CTRL_OP_LSB    0
`define FLC_CTRL_PD_BIT    8
`define FLC_STAT_BUSY_BIT  8
`define FLC_STAT_DONE_BIT  9
`define FLC_STAT_AWAKE_BIT 10
`endif

//--- common/flc_pkg.sv
// Purpose: types of the lock-bit flash host controller
// Assumes: nothing
// Notes:   op codes are written to the control register
package flc_pkg;
  typedef enum logic [2:0] {
    OP_NONE, OP_CLR_LOCK, OP_SET_LOCK, OP_CLR_STAT, OP_RD_STAT, OP_RD_ARRAY
  } op_type;
  typedef enum logic [1:0] {
    K_END, K_WRITE, K_READ, K_POLL
  } kind_type;
  typedef enum {
    ST_IDLE, ST_ISSUE, ST_WRITE, ST_READ
  } state_type;
endpackage : flc_pkg

//--- verilog/flc_host.sv
// Purpose: APB-driven host that sequences flash lock-bit commands
// Assumes: flash pins synchronous to mclk, 8-bit command data
// Notes:   device status byte is returned raw for software to decode
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "flc_params.svh"
module flc_host #(
  parameter int AW            = 21,
  parameter int WAKE_READ_NS  = 1000,
  parameter int WAKE_WRITE_NS = 1000
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          rst,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Flash pins
  output logic      [AW-1:0] flashAddr,
  output logic      [7:0]    dqOut,
  input  wire logic [7:0]    dqIn,
  output logic               dqOe,
  output logic               ceN,
  output logic               weN,
  output logic               oeN,
  output logic               resetPowerdownN
);
  localparam int WAKE_NS  = (WAKE_READ_NS > WAKE_WRITE_NS) ?
                            WAKE_READ_NS : WAKE_WRITE_NS;
  localparam int WAKE_CYC =
    (WAKE_NS + `FLC_CLK_PERIOD_NS - 1) / `FLC_CLK_PERIOD_NS;

  function automatic logic [9:0] seqAct(flc_pkg::op_type op,
                                        logic [2:0] step);
    flc_pkg::kind_type k;
    logic [7:0] d;
    k = flc_pkg::K_END;
    d = 8'h00;
    case (op)
      flc_pkg::OP_CLR_LOCK, flc_pkg::OP_SET_LOCK:
      begin
        case (step)
          3'h0:
          begin
            k = flc_pkg::K_WRITE;
            d = `FLC_CMD_LOCK_SETUP;
          end
          3'h1:
          begin
            k = flc_pkg::K_WRITE;
            d = (op == flc_pkg::OP_CLR_LOCK) ? `FLC_CMD_CLR_CONF
                                             : `FLC_CMD_SET_CONF;
          end
          3'h2:
            k = flc_pkg::K_POLL;
          3'h3:
          begin
            k = flc_pkg::K_WRITE;
            d = `FLC_CMD_READ_ARRAY;
          end
          default:
            k = flc_pkg::K_END;
        endcase
      end
      flc_pkg::OP_CLR_STAT:
      begin
        k = (step == 3'h0) ? flc_pkg::K_WRITE : flc_pkg::K_END;
        d = `FLC_CMD_CLR_STAT;
      end
      flc_pkg::OP_RD_STAT:
      begin
        k = (step == 3'h0) ? flc_pkg::K_WRITE :
            (step == 3'h1) ? flc_pkg::K_READ : flc_pkg::K_END;
        d = `FLC_CMD_READ_STAT;
      end
      flc_pkg::OP_RD_ARRAY:
      begin
        k = (step == 3'h0) ? flc_pkg::K_WRITE : flc_pkg::K_END;
        d = `FLC_CMD_READ_ARRAY;
      end
      default:
        k = flc_pkg::K_END;
    endcase
    return {k, d};
  endfunction : seqAct

  flc_pkg::state_type state_ff;
  flc_pkg::op_type    op_ff;
  logic [1:0]         curKind;
  logic [7:0]         curData;
  logic [2:0]         step_ff;
  logic [7:0]         cnt_ff;
  logic [AW-1:0]      addrReg_ff;
  logic               powerDown_ff;
  logic [7:0]         statusByte_ff;
  logic [7:0]         lastWr_ff;
  logic               done_ff;
  logic [11:0]        wakeCnt_ff;
  logic               awake;
  logic               apbWr;
  logic               apbSetup;
  logic               startReq;
  logic               mapped;
  logic               pollDone;

  assign {curKind, curData} = seqAct(op_ff, step_ff);
  assign awake    = resetPowerdownN && (wakeCnt_ff == 12'h000);
  assign apbWr    = psel && penable && pwrite;
  assign apbSetup = psel && !penable;
  assign mapped   = (paddr == `FLC_REG_CTRL) || (paddr == `FLC_REG_ADDR) ||
                    (paddr == `FLC_REG_STATUS);
  assign startReq = apbWr && (paddr == `FLC_REG_CTRL) &&
                    (pwdata[2:0] != 3'h0);
  assign pready   = psel && penable;
  assign pslverr  = psel && penable && !mapped;
  assign pollDone = (state_ff == flc_pkg::ST_READ) &&
                    (cnt_ff == 8'(`FLC_RD_CYC)) &&
                    (curKind == flc_pkg::K_POLL) && dqIn[`FLC_ST_READY_BIT];

  // Software registers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      powerDown_ff <= 1'b0;
      addrReg_ff   <= '0;
    end
    else if (apbWr && paddr == `FLC_REG_CTRL)
      powerDown_ff <= pwdata[`FLC_CTRL_PD_BIT];
    else if (apbWr && paddr == `FLC_REG_ADDR &&
             state_ff == flc_pkg::ST_IDLE)
      addrReg_ff <= pwdata[AW-1:0];
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (apbSetup)
    begin
      case (paddr)
        `FLC_REG_CTRL:
          prdata <= {23'h0, powerDown_ff, 5'h0, op_ff};
        `FLC_REG_ADDR:
          prdata <= 32'(addrReg_ff);
        `FLC_REG_STATUS:
          prdata <= {21'h0, awake, done_ff,
                     state_ff != flc_pkg::ST_IDLE, statusByte_ff};
        default:
          prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Reset pin and wake-up wait
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      resetPowerdownN <= 1'b0;
      wakeCnt_ff      <= 12'(WAKE_CYC);
    end
    else
    begin
      resetPowerdownN <= !powerDown_ff;
      if (!resetPowerdownN)
        wakeCnt_ff <= 12'(WAKE_CYC);
      else if (wakeCnt_ff != 12'h000)
        wakeCnt_ff <= wakeCnt_ff - 12'h001;
    end
  end

  // Command sequencer and flash strobes
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_ff      <= flc_pkg::ST_IDLE;
      op_ff         <= flc_pkg::OP_NONE;
      step_ff       <= 3'h0;
      cnt_ff        <= 8'h00;
      ceN           <= 1'b1;
      weN           <= 1'b1;
      oeN           <= 1'b1;
      dqOe          <= 1'b0;
      dqOut         <= 8'h00;
      flashAddr     <= '0;
      statusByte_ff <= 8'h00;
      lastWr_ff     <= 8'h00;
      done_ff       <= 1'b0;
    end
    else if (powerDown_ff || !awake)
    begin
      state_ff <= flc_pkg::ST_IDLE;
      ceN      <= 1'b1;
      weN      <= 1'b1;
      oeN      <= 1'b1;
      dqOe     <= 1'b0;
    end
    else
    begin
      case (state_ff)
        flc_pkg::ST_IDLE:
          if (startReq)
          begin
            op_ff     <= flc_pkg::op_type'(pwdata[2:0]);
            step_ff   <= 3'h0;
            done_ff   <= 1'b0;
            flashAddr <= addrReg_ff;
            state_ff  <= flc_pkg::ST_ISSUE;
          end
        flc_pkg::ST_ISSUE:
        begin
          cnt_ff <= 8'h00;
          case (curKind)
            flc_pkg::K_WRITE:
            begin
              dqOut    <= curData;
              dqOe     <= 1'b1;
              ceN      <= 1'b0;
              state_ff <= flc_pkg::ST_WRITE;
            end
            flc_pkg::K_READ, flc_pkg::K_POLL:
            begin
              ceN      <= 1'b0;
              oeN      <= 1'b0;
              state_ff <= flc_pkg::ST_READ;
            end
            default:
            begin
              done_ff  <= 1'b1;
              state_ff <= flc_pkg::ST_IDLE;
            end
          endcase
        end
        flc_pkg::ST_WRITE:
        begin
          cnt_ff <= cnt_ff + 8'h01;
          if (cnt_ff == 8'h00)
            weN <= 1'b0;
          if (cnt_ff == 8'(`FLC_WE_CYC))
            weN <= 1'b1;
          if (cnt_ff == 8'(`FLC_WE_CYC + 1))
          begin
            ceN       <= 1'b1;
            dqOe      <= 1'b0;
            lastWr_ff <= dqOut;
            step_ff   <= step_ff + 3'h1;
            state_ff  <= flc_pkg::ST_ISSUE;
          end
        end
        flc_pkg::ST_READ:
        begin
          cnt_ff <= cnt_ff + 8'h01;
          if (cnt_ff == 8'(`FLC_RD_CYC))
          begin
            statusByte_ff <= dqIn;
            ceN           <= 1'b1;
            oeN           <= 1'b1;
            state_ff      <= flc_pkg::ST_ISSUE;
            if (curKind != flc_pkg::K_POLL || dqIn[`FLC_ST_READY_BIT])
              step_ff <= step_ff + 3'h1;
          end
        end
        default:
          state_ff <= flc_pkg::ST_IDLE;
      endcase
    end
  end

  logic wrEnd;
  assign wrEnd = (state_ff == flc_pkg::ST_WRITE) &&
                 (cnt_ff == 8'(`FLC_WE_CYC));

  chk_clear_confirm: assert property (@(posedge mclk) disable iff (rst)
    wrEnd && dqOut == `FLC_CMD_CLR_CONF |-> lastWr_ff == `FLC_CMD_LOCK_SETUP)
    else $error("Clear confirm not preceded by setup byte");

  chk_set_confirm: assert property (@(posedge mclk) disable iff (rst)
    wrEnd && dqOut == `FLC_CMD_SET_CONF |->
      lastWr_ff == `FLC_CMD_LOCK_SETUP && flashAddr == addrReg_ff)
    else $error("Set confirm out of sequence or outside block");

  chk_poll_ready: assert property (@(posedge mclk) disable iff (rst)
    wrEnd && dqOut == `FLC_CMD_READ_ARRAY &&
    (op_ff == flc_pkg::OP_CLR_LOCK || op_ff == flc_pkg::OP_SET_LOCK) |->
      statusByte_ff[`FLC_ST_READY_BIT])
    else $error("Sequence moved on before ready bit was one");

  chk_read_array: assert property (@(posedge mclk) disable iff (rst)
    pollDone && !powerDown_ff |-> ##[1:20]
      (!weN && dqOe && dqOut == `FLC_CMD_READ_ARRAY) || powerDown_ff)
    else $error("Read-array byte missing after lock operation");

  chk_lock_finish: assert property (@(posedge mclk) disable iff (rst)
    $rose(done_ff) &&
    (op_ff == flc_pkg::OP_CLR_LOCK || op_ff == flc_pkg::OP_SET_LOCK) |->
      lastWr_ff == `FLC_CMD_READ_ARRAY)
    else $error("Lock operation ended without read-array");

  chk_wake_wait: assert property (@(posedge mclk) disable iff (rst)
    !ceN |-> resetPowerdownN && $past(wakeCnt_ff) == 12'h000)
    else $error("Flash selected before wake-up time elapsed");

  chk_wake_quiet: assert property (@(posedge mclk) disable iff (rst)
    $rose(resetPowerdownN) |-> ceN [*8])
    else $error("Flash selected right after reset pin rose");
endmodule : flc_host

//--- tb/flc_flash_model.sv
// Purpose: behavioural flash device with lock-bit status
// Assumes: strobes sampled on mclk
// Notes:   injectErr 1 fail, 2 supply, 3 protect
`timescale 1ns/1ps
module flc_flash_model (
  // Host side
  input  wire logic       mclk,
  input  wire logic       ceN,
  input  wire logic       weN,
  input  wire logic       oeN,
  input  wire logic       resetPowerdownN,
  input  wire logic [7:0] dqOut,
  output logic      [7:0] dqIn,
  output logic            stsOe,
  // Bench control
  input  wire logic [1:0] injectErr,
  input  wire logic [7:0] busyCyc
);
  logic [7:0] statusFf, errFf, busyFf, lastFf, val, failBit, errCode;
  logic       setupFf, statModeFf, weFf, rdAct, wrAcc;
  assign rdAct   = !ceN && !oeN && resetPowerdownN;
  assign wrAcc   = !weFf && weN && !ceN && resetPowerdownN;
  assign val     = statModeFf ? {busyFf == 8'h00, statusFf[6:0]} : 8'h5A;
  // Released bus shows the inverse, never the stale byte
  assign dqIn    = rdAct ? val : ~lastFf;
  assign stsOe   = resetPowerdownN && busyFf != 8'h00;
  assign failBit = dqOut == 8'h01 ? 8'h10 : 8'h20;
  assign errCode = injectErr == 2'd1 ? failBit :
                   injectErr == 2'd2 ? (failBit | 8'h08) :
                   injectErr == 2'd3 ? 8'h02 : 8'h00;
  always_ff @(posedge mclk)
  begin
    weFf <= weN;
    if (rdAct)
      lastFf <= val;
  end
  always_ff @(posedge mclk)
  begin
    if (!resetPowerdownN)
    begin
      statusFf   <= 8'h00;
      busyFf     <= 8'h00;
      setupFf    <= 1'b0;
      statModeFf <= 1'b0;
    end
    else if (busyFf != 8'h00)
    begin
      busyFf <= busyFf - 8'h01;
      if (busyFf == 8'h01)
        statusFf <= statusFf | errFf;
    end
    else if (wrAcc && setupFf)
    begin
      setupFf    <= 1'b0;
      statModeFf <= 1'b1;
      if (dqOut == 8'h01 || dqOut == 8'hD0)
      begin
        busyFf <= busyCyc | 8'h01;
        errFf  <= errCode;
      end
      else
        statusFf[5:4] <= 2'b11;
    end
    else if (wrAcc)
      case (dqOut)
        8'h60: setupFf <= 1'b1;
        8'h70: statModeFf <= 1'b1;
        8'h50: statusFf <= 8'h00;
        8'hFF: statModeFf <= 1'b0;
        default: ;
      endcase
  end
endmodule : flc_flash_model

//--- tb/test_flash_lockbit_status_control.sv
// Purpose: bench for the lock-bit flash host controller
// Assumes: device model answers on mclk
// Notes:   random busy times and addresses, fixed seed
`timescale 1ns/1ps
`include "flc_params.svh"
module test_flash_lockbit_status_control;
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, adr;
  logic [20:0] flashAddr;
  logic [7:0]  dqOut, dqIn, busyCyc, acc;
  logic        dqOe, ceN, weN, oeN, resetPowerdownN, stsOe, setOp;
  logic [1:0]  injectErr;
  int          errors, cmp_count, cyc, i;
  flc_host #(.WAKE_READ_NS(100), .WAKE_WRITE_NS(100)) i_flc_host (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flashAddr(flashAddr),
    .dqOut(dqOut), .dqIn(dqIn), .dqOe(dqOe), .ceN(ceN), .weN(weN),
    .oeN(oeN), .resetPowerdownN(resetPowerdownN));
  flc_flash_model i_flc_flash_model (
    .mclk(mclk), .ceN(ceN), .weN(weN), .oeN(oeN),
    .resetPowerdownN(resetPowerdownN), .dqOut(dqOut), .dqIn(dqIn),
    .stsOe(stsOe), .injectErr(injectErr), .busyCyc(busyCyc));
  always #12.5 mclk = ~mclk;
  function automatic logic [7:0] expErr(input logic [1:0] inj,
                                        input logic       isSet);
    logic [7:0] f;
    f = isSet ? 8'h10 : 8'h20;
    case (inj)
      2'd1: return f;
      2'd2: return f | 8'h08;
      2'd3: return 8'h02;
      default: return 8'h00;
    endcase
  endfunction : expErr
  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic waitAwake;
    int n;
    n = 0;
    do
    begin
      apb(1'b0, `FLC_REG_STATUS, 32'h0);
      n++;
    end
    while (rd[`FLC_STAT_AWAKE_BIT] !== 1'b1 && n < 100);
    check(rd[`FLC_STAT_AWAKE_BIT], 1'b1);
  endtask : waitAwake
  task automatic runOp(input flc_pkg::op_type op);
    int n;
    apb(1'b1, `FLC_REG_CTRL, {29'h0, op});
    n = 0;
    do
    begin
      apb(1'b0, `FLC_REG_STATUS, 32'h0);
      n++;
    end
    while (rd[`FLC_STAT_BUSY_BIT] !== 1'b0 && n < 2000);
    check(rd[`FLC_STAT_DONE_BIT], 1'b1);
    check(stsOe, 1'b0);
  endtask : runOp
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      errors++;
      report_and_stop;
    end
  end
  initial
  begin
    mclk = 0; rst = 1; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; injectErr = 0; busyCyc = 8'h05; acc = 0;
    void'($urandom(32'h27D55F0D));
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    waitAwake;
    for (i = 0; i < 8; i++)
    begin
      setOp = i[2];
      injectErr <= i[1:0];
      busyCyc <= 8'($urandom_range(1, 40));
      adr = $urandom & 32'h001FFFFF;
      apb(1'b1, `FLC_REG_ADDR, adr);
      runOp(setOp ? flc_pkg::OP_SET_LOCK : flc_pkg::OP_CLR_LOCK);
      check(32'(flashAddr), adr);
      acc = acc | expErr(i[1:0], setOp);
      check(rd[7:0], 8'h80 | acc);
      runOp(flc_pkg::OP_RD_STAT);
      check(rd[7:0], 8'h80 | acc);
      if (i == 3)
      begin
        runOp(flc_pkg::OP_CLR_STAT);
        acc = 8'h00;
        runOp(flc_pkg::OP_RD_STAT);
        check(rd[7:0], 8'h80);
      end
    end
    busyCyc <= 8'hC8;
    apb(1'b1, `FLC_REG_CTRL, {29'h0, flc_pkg::OP_CLR_LOCK});
    repeat (30) @(posedge mclk);
    check(stsOe, 1'b1);
    apb(1'b1, `FLC_REG_CTRL, 32'h00000100);
    apb(1'b0, `FLC_REG_STATUS, 32'h0);
    check({rd[10], rd[8]}, 2'b00);
    check(stsOe, 1'b0);
    apb(1'b1, `FLC_REG_CTRL, 32'h00000000);
    waitAwake;
    runOp(flc_pkg::OP_RD_STAT);
    check(rd[7:0], 8'h80);
    runOp(flc_pkg::OP_RD_ARRAY);
    apb(1'b0, 12'h00C, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    report_and_stop;
  end
endmodule : test_flash_lockbit_status_control
